// file: src/csi_consts.svh
// Bit positions, reset values and codes for the status and interrupt control registers.
`ifndef CSI_CONSTS_SVH
`define CSI_CONSTS_SVH

// ----------------------------------------------------------------------
// Register selects
// ----------------------------------------------------------------------
`define CSI_SEL_STATUS 1'h0
`define CSI_SEL_INTERRUPT_CONTROL 1'h1

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define CSI_ST_NMI 19
`define CSI_ST_FLOOR_HI 18
`define CSI_ST_FLOOR_LO_MSB 16
`define CSI_ST_FLOOR_LO_LSB 10
`define CSI_ST_UBM 4
`define CSI_ST_ERL 2
`define CSI_ST_EXL 1
`define CSI_ST_IE 0

// ----------------------------------------------------------------------
// Interrupt control register fields
// ----------------------------------------------------------------------
`define CSI_IC_PF 22
`define CSI_IC_CHAIN 21
`define CSI_IC_DEC_MSB 20
`define CSI_IC_DEC_LSB 16
`define CSI_IC_LVLCLR 15
`define CSI_IC_APE 14
`define CSI_IC_KSTK 13
`define CSI_IC_VS_MSB 9
`define CSI_IC_VS_LSB 5

// ----------------------------------------------------------------------
// Reset values and derived constants
// ----------------------------------------------------------------------
`define CSI_DEC_RESET 5'h03
`define CSI_DEC_MIN 5'h03
`define CSI_VS_SHIFT 5'h00
`define CSI_WORD_SHIFT 2'h0
`define CSI_UNMAPPED_BITS 29

`endif

// file: src/csi_pkg.sv
// Types shared by the processor status and interrupt control block.
package csi_pkg;

    // Kind of exception being entered, as reported by the core.
    typedef enum logic [2:0] {
        EXC_HARD_RESET = 3'h0,
        EXC_SOFT_RESET = 3'h1,
        EXC_NMI = 3'h2,
        EXC_CACHE_ERR = 3'h3,
        EXC_OTHER = 3'h4
    } csi_exc_kind_t;

    // Automatic prologue sequencer states, one-hot.
    typedef enum logic [2:0] {
        PRO_IDLE = 3'b001,
        PRO_COPY = 3'b010,
        PRO_DEC = 3'b100
    } csi_pro_state_t;

endpackage : csi_pkg

// file: src/csi_status_ctrl.sv
// Processor status low half, interrupt control register and exception level logic.
`timescale 1ns/1ps
`include "csi_consts.svh"

module csi_status_ctrl #(
    parameter int ADDR_W = 32
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Coprocessor register port.
    input wire logic reg_sel,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // Exception and instruction events from the core.
    input wire logic exc_take,
    input wire csi_pkg::csi_exc_kind_t exc_kind,
    input wire logic return_from_exception,
    input wire logic return_chain_instr,
    input wire logic irq_off_instr,
    input wire logic irq_on_instr,
    input wire logic prologue_start,
    // Interrupt request and address check.
    input wire logic req_valid,
    input wire logic [7:0] req_priority,
    input wire logic [ADDR_W-1:0] access_addr,
    // Mode and gating results.
    output logic kernel_mode,
    output logic irq_signal,
    output logic ret_use_error_pc,
    output logic save_return_state,
    output logic low_user_unmapped,
    // Interrupt control results.
    output logic prefetch_vectors,
    output logic chain_irqs,
    output logic [9:0] vector_spacing_bytes,
    // Prologue sequencer pulses.
    output logic copy_prev_stack,
    output logic sp_dec_valid,
    output logic [6:0] sp_dec_bytes
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    // The unmapped window is the low 2^29 bytes, so narrower addresses make no sense.
    if (ADDR_W <= `CSI_UNMAPPED_BITS) begin : g_bad_addr_w
        $error("ADDR_W must exceed the unmapped window width");
    end

    // ------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------
    logic rst_meta_n;
    logic rst_sync_n;

    // Release is synchronised so that no flop leaves reset on a different edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ------------------------------------------------------------------
    // Status register state
    // ------------------------------------------------------------------
    logic nmi_flag, next_nmi_flag;
    logic [7:0] priority_floor, next_priority_floor;
    logic user_base_mode, next_user_base_mode;
    logic error_level, next_error_level;
    logic exception_level, next_exception_level;
    logic master_irq_gate, next_master_irq_gate;
    logic level_clear_now;

    // ------------------------------------------------------------------
    // Interrupt control register state
    // ------------------------------------------------------------------
    logic ic_prefetch, next_ic_prefetch;
    logic ic_chain, next_ic_chain;
    logic [4:0] stack_decrement_words, next_stack_decrement_words;
    logic level_clear_on_prologue, next_level_clear_on_prologue;
    logic auto_prologue_on, next_auto_prologue_on;
    logic kernel_stack_choice, next_kernel_stack_choice;
    logic [4:0] vector_spacing, next_vector_spacing;

    // ------------------------------------------------------------------
    // Prologue sequencer state
    // ------------------------------------------------------------------
    csi_pkg::csi_pro_state_t pro_state, next_pro_state;
    logic [4:0] dec_words;

    // Decrement field values below three all mean three words.
    // The next field value is used so that the byte count agrees with the register on the same edge.
    assign dec_words = (next_stack_decrement_words < `CSI_DEC_MIN) ? `CSI_DEC_MIN
        : next_stack_decrement_words;

    // Sequencer: optional stack copy, then the decrement step.
    always_comb begin
        next_pro_state = pro_state;
        case (pro_state)
            csi_pkg::PRO_IDLE: begin
                if (prologue_start && auto_prologue_on) begin
                    next_pro_state = kernel_stack_choice ? csi_pkg::PRO_DEC : csi_pkg::PRO_COPY;
                end
            end
            csi_pkg::PRO_COPY: begin
                next_pro_state = csi_pkg::PRO_DEC;
            end
            csi_pkg::PRO_DEC: begin
                next_pro_state = csi_pkg::PRO_IDLE;
            end
            default: begin
                next_pro_state = csi_pkg::PRO_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pro_state <= csi_pkg::PRO_IDLE;
        end else begin
            pro_state <= next_pro_state;
        end
    end

    // Levels are cleared in the decrement step of the prologue and on a chained return.
    assign level_clear_now = level_clear_on_prologue
        && ((pro_state == csi_pkg::PRO_DEC) || return_chain_instr);

    // ------------------------------------------------------------------
    // Status next-state logic
    // ------------------------------------------------------------------
    // Hardware events are applied after the software write so that they win over it; among them a set wins over a clear.
    always_comb begin
        next_nmi_flag = nmi_flag;
        next_priority_floor = priority_floor;
        next_user_base_mode = user_base_mode;
        next_error_level = error_level;
        next_exception_level = exception_level;
        next_master_irq_gate = master_irq_gate;
        if (reg_wr && (reg_sel == `CSI_SEL_STATUS)) begin
            next_nmi_flag = nmi_flag & reg_wdata[`CSI_ST_NMI];
            next_priority_floor = {reg_wdata[`CSI_ST_FLOOR_HI],
                reg_wdata[`CSI_ST_FLOOR_LO_MSB:`CSI_ST_FLOOR_LO_LSB]};
            next_user_base_mode = reg_wdata[`CSI_ST_UBM];
            next_error_level = reg_wdata[`CSI_ST_ERL];
            next_exception_level = reg_wdata[`CSI_ST_EXL];
            next_master_irq_gate = reg_wdata[`CSI_ST_IE];
        end
        if (irq_off_instr) begin
            next_master_irq_gate = 1'b0;
        end
        if (irq_on_instr) begin
            next_master_irq_gate = 1'b1;
        end
        // A return drops the error level first, otherwise the exception level.
        if (return_from_exception) begin
            if (error_level) begin
                next_error_level = 1'b0;
            end else begin
                next_exception_level = 1'b0;
            end
        end
        if (level_clear_now) begin
            next_user_base_mode = 1'b0;
            next_error_level = 1'b0;
            next_exception_level = 1'b0;
        end
        if (exc_take) begin
            case (exc_kind)
                csi_pkg::EXC_HARD_RESET, csi_pkg::EXC_SOFT_RESET: begin
                    next_error_level = 1'b1;
                    next_nmi_flag = 1'b0;
                end
                csi_pkg::EXC_NMI: begin
                    next_error_level = 1'b1;
                    next_nmi_flag = 1'b1;
                end
                csi_pkg::EXC_CACHE_ERR: begin
                    next_error_level = 1'b1;
                end
                default: begin
                    next_exception_level = 1'b1;
                end
            endcase
        end
    end

    // Error level is up out of reset, as after a hard reset entry.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            nmi_flag <= 1'b0;
            priority_floor <= 8'h00;
            user_base_mode <= 1'b0;
            error_level <= 1'b1;
            exception_level <= 1'b0;
            master_irq_gate <= 1'b0;
        end else begin
            nmi_flag <= next_nmi_flag;
            priority_floor <= next_priority_floor;
            user_base_mode <= next_user_base_mode;
            error_level <= next_error_level;
            exception_level <= next_exception_level;
            master_irq_gate <= next_master_irq_gate;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt control next-state logic
    // ------------------------------------------------------------------
    // Reserved spacing codes are stored as written; software must avoid them.
    always_comb begin
        next_ic_prefetch = ic_prefetch;
        next_ic_chain = ic_chain;
        next_stack_decrement_words = stack_decrement_words;
        next_level_clear_on_prologue = level_clear_on_prologue;
        next_auto_prologue_on = auto_prologue_on;
        next_kernel_stack_choice = kernel_stack_choice;
        next_vector_spacing = vector_spacing;
        if (reg_wr && (reg_sel == `CSI_SEL_INTERRUPT_CONTROL)) begin
            next_ic_prefetch = reg_wdata[`CSI_IC_PF];
            next_ic_chain = reg_wdata[`CSI_IC_CHAIN];
            next_stack_decrement_words = reg_wdata[`CSI_IC_DEC_MSB:`CSI_IC_DEC_LSB];
            next_level_clear_on_prologue = reg_wdata[`CSI_IC_LVLCLR];
            next_auto_prologue_on = reg_wdata[`CSI_IC_APE];
            next_kernel_stack_choice = reg_wdata[`CSI_IC_KSTK];
            next_vector_spacing = reg_wdata[`CSI_IC_VS_MSB:`CSI_IC_VS_LSB];
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ic_prefetch <= 1'b0;
            ic_chain <= 1'b0;
            stack_decrement_words <= `CSI_DEC_RESET;
            level_clear_on_prologue <= 1'b0;
            auto_prologue_on <= 1'b0;
            kernel_stack_choice <= 1'b0;
            vector_spacing <= 5'h00;
        end else begin
            ic_prefetch <= next_ic_prefetch;
            ic_chain <= next_ic_chain;
            stack_decrement_words <= next_stack_decrement_words;
            level_clear_on_prologue <= next_level_clear_on_prologue;
            auto_prologue_on <= next_auto_prologue_on;
            kernel_stack_choice <= next_kernel_stack_choice;
            vector_spacing <= next_vector_spacing;
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    logic [31:0] next_reg_rdata;
    logic next_kernel_mode;
    logic next_irq_signal;
    logic next_low_user_unmapped;

    // Outputs other than the read data follow the next state so that they agree with the registers on the same edge.
    always_comb begin
        next_reg_rdata = 32'h0000_0000;
        if (reg_sel == `CSI_SEL_STATUS) begin
            next_reg_rdata[`CSI_ST_NMI] = nmi_flag;
            next_reg_rdata[`CSI_ST_FLOOR_HI] = priority_floor[7];
            next_reg_rdata[`CSI_ST_FLOOR_LO_MSB:`CSI_ST_FLOOR_LO_LSB] = priority_floor[6:0];
            next_reg_rdata[`CSI_ST_UBM] = user_base_mode;
            next_reg_rdata[`CSI_ST_ERL] = error_level;
            next_reg_rdata[`CSI_ST_EXL] = exception_level;
            next_reg_rdata[`CSI_ST_IE] = master_irq_gate;
        end else begin
            next_reg_rdata[`CSI_IC_PF] = ic_prefetch;
            next_reg_rdata[`CSI_IC_CHAIN] = ic_chain;
            next_reg_rdata[`CSI_IC_DEC_MSB:`CSI_IC_DEC_LSB] = stack_decrement_words;
            next_reg_rdata[`CSI_IC_LVLCLR] = level_clear_on_prologue;
            next_reg_rdata[`CSI_IC_APE] = auto_prologue_on;
            next_reg_rdata[`CSI_IC_KSTK] = kernel_stack_choice;
            next_reg_rdata[`CSI_IC_VS_MSB:`CSI_IC_VS_LSB] = vector_spacing;
        end
        next_kernel_mode = !next_user_base_mode || next_error_level || next_exception_level;
        next_irq_signal = req_valid && next_master_irq_gate && !next_error_level
            && !next_exception_level
            && (req_priority > next_priority_floor);
        next_low_user_unmapped = next_error_level
            && (access_addr[ADDR_W-1:`CSI_UNMAPPED_BITS] == '0);
    end

    // Read data is taken one cycle after the select is presented.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= 32'h0000_0000;
            kernel_mode <= 1'b1;
            irq_signal <= 1'b0;
            ret_use_error_pc <= 1'b1;
            save_return_state <= 1'b1;
            low_user_unmapped <= 1'b0;
            prefetch_vectors <= 1'b0;
            chain_irqs <= 1'b0;
            vector_spacing_bytes <= 10'h000;
            copy_prev_stack <= 1'b0;
            sp_dec_valid <= 1'b0;
            sp_dec_bytes <= 7'h00;
        end else begin
            reg_rdata <= next_reg_rdata;
            kernel_mode <= next_kernel_mode;
            irq_signal <= next_irq_signal;
            ret_use_error_pc <= next_error_level;
            save_return_state <= !next_exception_level;
            low_user_unmapped <= next_low_user_unmapped;
            prefetch_vectors <= next_ic_prefetch;
            chain_irqs <= next_ic_chain;
            vector_spacing_bytes <= {next_vector_spacing, `CSI_VS_SHIFT};
            copy_prev_stack <= (next_pro_state == csi_pkg::PRO_COPY);
            sp_dec_valid <= (next_pro_state == csi_pkg::PRO_DEC);
            sp_dec_bytes <= {dec_words, `CSI_WORD_SHIFT};
        end
    end

endmodule : csi_status_ctrl

// file: tb/csi_status_ctrl_asserts.sv
// Port-level concurrent checks for the status and interrupt control block.
`timescale 1ns/1ps
module csi_status_ctrl_asserts #(
    parameter int ADDR_W = 32
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Register port and core events.
    input wire logic reg_sel,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    input wire logic exc_take,
    input wire csi_pkg::csi_exc_kind_t exc_kind,
    input wire logic irq_off_instr,
    input wire logic irq_on_instr,
    input wire logic req_valid,
    input wire logic [ADDR_W-1:0] access_addr,
    // Results.
    input wire logic kernel_mode,
    input wire logic irq_signal,
    input wire logic ret_use_error_pc,
    input wire logic save_return_state,
    input wire logic low_user_unmapped,
    input wire logic prefetch_vectors,
    input wire logic [9:0] vector_spacing_bytes,
    input wire logic copy_prev_stack,
    input wire logic sp_dec_valid,
    input wire logic [6:0] sp_dec_bytes
);
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // The copy step is always followed by exactly one decrement pulse.
    sequence s_copy;
        copy_prev_stack;
    endsequence
    sequence s_dec_once;
        sp_dec_valid ##1 !sp_dec_valid;
    endsequence
    property p_copy_then_dec;
        s_copy |=> s_dec_once;
    endproperty

    a_exc_kernel: assert property (exc_take |=> kernel_mode) else $error("kernel mode missing after exception");
    a_exc_err_level: assert property (exc_take && exc_kind != csi_pkg::EXC_OTHER |=> ret_use_error_pc)
        else $error("error level missing after reset class exception");
    a_exc_exc_level: assert property (exc_take && exc_kind == csi_pkg::EXC_OTHER |=> !save_return_state)
        else $error("exception level missing after exception");
    a_user_no_level: assert property (!kernel_mode |-> save_return_state && !ret_use_error_pc)
        else $error("user mode with a level bit set");
    a_irq_needs_req: assert property (irq_signal |-> $past(req_valid)) else $error("interrupt without request");
    a_unmap_window: assert property (low_user_unmapped |-> ret_use_error_pc && $past(access_addr) < 2**29)
        else $error("unmapped window outside error level or range");
    a_copy_dec_order: assert property (p_copy_then_dec) else $error("decrement step not after copy");
    a_dec_min_words: assert property (sp_dec_valid |-> sp_dec_bytes >= 7'h0C && sp_dec_bytes[1:0] == 2'h0)
        else $error("stack decrement below three words");
    a_pf_follows: assert property (reg_wr && reg_sel |=> prefetch_vectors == $past(reg_wdata[22]))
        else $error("prefetch control not updated");
    a_vs_follows: assert property (reg_wr && reg_sel |=> vector_spacing_bytes == {$past(reg_wdata[9:5]), 5'h00})
        else $error("vector spacing not updated");
    a_irq_gate_off: assert property (irq_off_instr && !irq_on_instr ##1 !irq_on_instr && !reg_wr |=> !irq_signal)
        else $error("interrupt signalled after gate off");
endmodule : csi_status_ctrl_asserts

// file: tb/csi_status_ctrl_bench.sv
// Self-checking bench for the status and interrupt control block.
`timescale 1ns/1ps
module csi_status_ctrl_bench;
    // ------------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_sel = 1'b0;
    logic reg_wr = 1'b0;
    logic [31:0] reg_wdata = 32'h00000000;
    logic [5:0] ev = 6'h00;
    csi_pkg::csi_exc_kind_t exc_kind = csi_pkg::EXC_OTHER;
    logic req_valid = 1'b0;
    logic [7:0] req_priority = 8'h00;
    logic [31:0] access_addr = 32'h00000000;
    logic [31:0] reg_rdata;
    logic kernel_mode, irq_signal, ret_use_error_pc, save_return_state, low_user_unmapped;
    logic prefetch_vectors, chain_irqs, copy_prev_stack, sp_dec_valid;
    logic [9:0] vector_spacing_bytes;
    logic [6:0] sp_dec_bytes;
    int err_total = 0;
    int num_checks = 0;
    logic [4:0] codes [6] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
    logic [31:0] exc_exp [5] = '{32'h00000004, 32'h00000004, 32'h00080004, 32'h00000004, 32'h00000002};

    // Event pulses share one vector so a single assignment raises one of them.
    csi_status_ctrl dut (.clk(clk), .rst_n(rst_n), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .exc_take(ev[0]), .exc_kind(exc_kind), .return_from_exception(ev[1]),
        .return_chain_instr(ev[2]), .irq_off_instr(ev[3]), .irq_on_instr(ev[4]), .prologue_start(ev[5]),
        .req_valid(req_valid), .req_priority(req_priority), .access_addr(access_addr), .kernel_mode(kernel_mode),
        .irq_signal(irq_signal), .ret_use_error_pc(ret_use_error_pc), .save_return_state(save_return_state),
        .low_user_unmapped(low_user_unmapped), .prefetch_vectors(prefetch_vectors), .chain_irqs(chain_irqs),
        .vector_spacing_bytes(vector_spacing_bytes), .copy_prev_stack(copy_prev_stack),
        .sp_dec_valid(sp_dec_valid), .sp_dec_bytes(sp_dec_bytes));

    // Free-running core clock at 100 MHz.
    initial begin
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task finish_test;
        $display("Checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    // Writes hold the strobe for one edge, then leave one idle edge for the outputs.
    task wr(input logic sel, input logic [31:0] d);
        reg_sel <= sel;
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    task rd(input logic sel, input logic [31:0] exp, input logic [31:0] m);
        reg_sel <= sel;
        @(posedge clk);
        @(negedge clk);
        chk_word(reg_rdata & m, exp);
        @(posedge clk);
    endtask : rd

    task fire(input int w);
        ev <= 6'h01 << w;
        @(posedge clk);
        ev <= 6'h00;
    endtask : fire

    task prio(input logic [7:0] p, input logic exp);
        req_priority <= p;
        @(posedge clk);
        @(negedge clk);
        chk_bit(irq_signal, exp);
        @(posedge clk);
    endtask : prio

    // Records where each prologue pulse lands so the exact latency does not matter.
    task prologue(input logic cp, input logic run, input logic [6:0] bytes);
        int ci;
        int di;
        logic [6:0] db;
        ci = -1;
        di = -1;
        db = 7'h00;
        fire(5);
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            if (copy_prev_stack === 1'b1) ci = i;
            if (sp_dec_valid === 1'b1) begin
                di = i;
                db = sp_dec_bytes;
            end
        end
        @(posedge clk);
        chk_bit(di >= 0, run);
        chk_bit(ci >= 0, cp && run);
        if (run && cp) chk_bit(di == ci + 1, 1'b1);
        if (run) chk_word({25'h0000000, db}, {25'h0000000, bytes});
    endtask : prologue

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(1'b0, 32'h00000004, 32'hFFFFFFFF);
        rd(1'b1, 32'h00030000, 32'hFFFFFFFF);
        chk_bit(ret_use_error_pc, 1'b1);
        wr(1'b1, 32'hFFFFFFFF);
        rd(1'b1, 32'h007FE3E0, 32'hFFFFFFFF);
        chk_bit(prefetch_vectors, 1'b1);
        chk_bit(chain_irqs, 1'b1);
        wr(1'b1, 32'h00000000);
        chk_bit(chain_irqs, 1'b0);
        chk_word({25'h0000000, sp_dec_bytes}, 32'h0000000C);
        foreach (codes[k]) begin
            wr(1'b1, {22'h000000, codes[k], 5'h00});
            chk_word({22'h000000, vector_spacing_bytes}, {22'h000000, codes[k], 5'h00});
        end
        wr(1'b0, 32'hFFFFFFFF);
        rd(1'b0, 32'h0005FC17, 32'hFFFFFFFF);
        // Each exception kind from a cleared status, the NMI flag cleared by software next time.
        for (int k = 0; k < 5; k++) begin
            wr(1'b0, 32'h00000000);
            rd(1'b0, 32'h00000000, 32'hFFFFFFFF);
            exc_kind <= csi_pkg::csi_exc_kind_t'(k);
            fire(0);
            rd(1'b0, exc_exp[k], 32'hFFFFFFFF);
        end
        wr(1'b0, 32'h00000006);
        fire(1);
        rd(1'b0, 32'h00000002, 32'hFFFFFFFF);
        fire(1);
        rd(1'b0, 32'h00000000, 32'hFFFFFFFF);
        wr(1'b0, 32'h00000010);
        chk_bit(kernel_mode, 1'b0);
        wr(1'b0, 32'h00000012);
        chk_bit(kernel_mode, 1'b1);
        chk_bit(save_return_state, 1'b0);
        wr(1'b0, 32'h00000014);
        chk_bit(kernel_mode, 1'b1);
        access_addr <= 32'h1FFFFFFF;
        prio(8'h00, 1'b0);
        chk_bit(low_user_unmapped, 1'b1);
        access_addr <= 32'h20000000;
        prio(8'h00, 1'b0);
        chk_bit(low_user_unmapped, 1'b0);
        // Priority floor of five with the gate open, then the top floor bit alone.
        wr(1'b0, 32'h00001401);
        req_valid <= 1'b1;
        prio(8'h05, 1'b0);
        prio(8'h06, 1'b1);
        fire(3);
        prio(8'h06, 1'b0);
        fire(4);
        prio(8'h06, 1'b1);
        wr(1'b0, 32'h00040001);
        prio(8'h80, 1'b0);
        prio(8'h81, 1'b1);
        wr(1'b0, 32'h00040003);
        prio(8'h81, 1'b0);
        req_valid <= 1'b0;
        wr(1'b1, 32'h0002C000);
        wr(1'b0, 32'h00000012);
        prologue(1'b1, 1'b1, 7'h0C);
        rd(1'b0, 32'h00000000, 32'h00000016);
        wr(1'b1, 32'h00056000);
        wr(1'b0, 32'h00000002);
        prologue(1'b0, 1'b1, 7'h14);
        rd(1'b0, 32'h00000002, 32'h00000006);
        wr(1'b1, 32'h00058000);
        prologue(1'b0, 1'b0, 7'h00);
        wr(1'b0, 32'h00000006);
        fire(2);
        rd(1'b0, 32'h00000000, 32'h00000006);
        finish_test();
    end

    // Cuts a hung run short and reports it as a mismatch.
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("FAIL %0t run limit reached", $time);
        finish_test();
    end
endmodule : csi_status_ctrl_bench

bind csi_status_ctrl csi_status_ctrl_asserts #(.ADDR_W(ADDR_W)) u_asserts (.clk(clk), .rst_n(rst_n),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .exc_take(exc_take), .exc_kind(exc_kind),
    .irq_off_instr(irq_off_instr), .irq_on_instr(irq_on_instr), .req_valid(req_valid), .access_addr(access_addr),
    .kernel_mode(kernel_mode), .irq_signal(irq_signal), .ret_use_error_pc(ret_use_error_pc),
    .save_return_state(save_return_state), .low_user_unmapped(low_user_unmapped),
    .prefetch_vectors(prefetch_vectors), .vector_spacing_bytes(vector_spacing_bytes),
    .copy_prev_stack(copy_prev_stack), .sp_dec_valid(sp_dec_valid), .sp_dec_bytes(sp_dec_bytes));
